// *** rtl/mtd_axis_cmp.sv ***
// One axis comparator: magnitude of a raw signed sample against a threshold.
// Assumes the raw sample is two's complement, taken before offset correction.
`timescale 1ns/10ps
`default_nettype none
module mtd_axis_cmp #(
    parameter int SAMPLE_W = mtd_pkg::SAMPLE_W,
    parameter int THS_W = mtd_pkg::THS_W
) (
    // Sample and threshold
    input wire logic [SAMPLE_W-1:0] sample_raw,
    input wire logic [THS_W-1:0] threshold,
    // Results
    output logic at_or_below,
    output logic at_or_above,
    output logic negative
);
    logic [SAMPLE_W-1:0] magnitude;
    logic [SAMPLE_W-1:0] ths_wide;

    // Full-scale negative maps to its true magnitude, no wrap at 16 bits
    always_comb begin
        negative = sample_raw[SAMPLE_W-1]; // see [R4]
        magnitude = negative ? SAMPLE_W'(~sample_raw + 1'b1) : sample_raw;
        ths_wide = SAMPLE_W'(threshold); // see [R5]
        at_or_below = (magnitude <= ths_wide); // see [R15]
        at_or_above = (magnitude >= ths_wide); // see [R16]
    end
endmodule : mtd_axis_cmp
`default_nettype wire

// *** rtl/mtd_debounce.sv ***
// Debounce counter stepped once per effective data rate period.
// Assumes step is a one-cycle pulse and the target is stable around it.
`timescale 1ns/10ps
`default_nettype none
module mtd_debounce #(
    parameter int COUNT_W = mtd_pkg::COUNT_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Control
    input wire logic step,
    input wire logic condition,
    input wire logic clear_mode,
    input wire logic [COUNT_W-1:0] target,
    // Result
    output logic hit,
    output logic [COUNT_W-1:0] count
);
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;

    always_comb begin
        count_d = count_q;
        hit = 1'b0;
        if (step) begin
            if (condition) begin
                // Never runs past the target, also after a lowered target
                if (count_q < target) begin
                    count_d = count_q + 1'b1; // see [R11]
                end else begin
                    count_d = target; // see [R11]
                end
                hit = (count_d == target); // see [R10]
            end else if (clear_mode) begin
                count_d = '0; // see [R8]
            end else if (count_q != '0) begin
                count_d = count_q - 1'b1; // see [R9]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d; // see [R12]
        end
    end

    assign count = count_q;
endmodule : mtd_debounce
`default_nettype wire

// *** rtl/mtd_top.sv ***
// Magnetic threshold event detector: registers, axis compare, debounce,
// event source register and interrupt routing.
// Assumes odr_tick pulses once per system data rate period, with fresh raw
// samples on mag_*_raw in that cycle, and register strobes one cycle wide.
`timescale 1ns/10ps
`default_nettype none
module mtd_top #(
    parameter int SAMPLE_W = mtd_pkg::SAMPLE_W,
    parameter int THS_W = mtd_pkg::THS_W,
    parameter int COUNT_W = mtd_pkg::COUNT_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    // Sample timing and raw data
    input wire logic odr_tick,
    input wire logic hybrid_mode,
    input wire logic [SAMPLE_W-1:0] mag_x_raw,
    input wire logic [SAMPLE_W-1:0] mag_y_raw,
    input wire logic [SAMPLE_W-1:0] mag_z_raw,
    // Other interrupt sources sharing the lines
    input wire logic irq_one_other,
    input wire logic irq_two_other,
    // Event outputs
    output logic event_active_flag,
    output logic wake_event,
    output logic irq_line_one,
    output logic irq_line_two
);
    // Configuration and threshold registers
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] ths_x_hi_q;
    logic [7:0] ths_x_hi_d;
    logic [7:0] ths_x_lo_q;
    logic [7:0] ths_x_lo_d;
    logic [7:0] ths_y_hi_q;
    logic [7:0] ths_y_hi_d;
    logic [7:0] ths_y_lo_q;
    logic [7:0] ths_y_lo_d;
    logic [7:0] ths_z_hi_q;
    logic [7:0] ths_z_hi_d;
    logic [7:0] ths_z_lo_q;
    logic [7:0] ths_z_lo_d;
    logic [COUNT_W-1:0] count_tgt_q;
    logic [COUNT_W-1:0] count_tgt_d;

    // Step divider for hybrid mode
    logic hyb_phase_q;
    logic hyb_phase_d;
    logic step;

    // Source state
    logic active_q;
    logic active_d;
    logic [2:0] high_q;
    logic [2:0] high_d;
    logic [2:0] pol_q;
    logic [2:0] pol_d;

    // Read data
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;

    // Datapath
    logic [THS_W-1:0] ths [3];
    logic [SAMPLE_W-1:0] raw [3];
    logic [2:0] below;
    logic [2:0] above;
    logic [2:0] negative;
    logic [2:0] axis_en;
    logic [2:0] axis_hit;
    logic condition;
    logic hit;
    logic src_read;
    logic [7:0] src_view;

    always_comb begin
        ths[0] = THS_W'({ths_x_hi_q[6:0], ths_x_lo_q}); // see [R7]
        ths[1] = THS_W'({ths_y_hi_q[6:0], ths_y_lo_q}); // see [R7]
        ths[2] = THS_W'({ths_z_hi_q[6:0], ths_z_lo_q}); // see [R7]
        raw[0] = mag_x_raw;
        raw[1] = mag_y_raw;
        raw[2] = mag_z_raw;
        axis_en = {cfg_q[mtd_pkg::CFG_EN_Z], cfg_q[mtd_pkg::CFG_EN_Y], cfg_q[mtd_pkg::CFG_EN_X]};
    end

    // Raw samples only: offset correction happens downstream of this block
    for (genvar i = 0; i < 3; i++) begin : g_axis
        mtd_axis_cmp #(
            .SAMPLE_W(SAMPLE_W),
            .THS_W(THS_W)
        ) u_cmp (
            .sample_raw(raw[i]), // see [R6]
            .threshold(ths[i]),
            .at_or_below(below[i]),
            .at_or_above(above[i]),
            .negative(negative[i])
        );
    end

    // Combine the enabled axes into one event condition
    always_comb begin
        if (cfg_q[mtd_pkg::CFG_LOGIC_OR]) begin
            axis_hit = above & axis_en; // see [R16]
            condition = |axis_hit; // see [R16]
        end else begin
            axis_hit = below & axis_en; // see [R15]
            // No enabled axis means no event rather than a vacuous true
            condition = (|axis_en) && (&(below | ~axis_en)); // see [R15]
        end
    end

    // Hybrid mode halves the per-sensor rate, so every other tick counts
    always_comb begin
        hyb_phase_d = hyb_phase_q;
        step = 1'b0;
        if (!hybrid_mode) begin
            hyb_phase_d = 1'b0;
            step = odr_tick; // see [R12]
        end else if (odr_tick) begin
            hyb_phase_d = ~hyb_phase_q;
            step = hyb_phase_q; // see [R13]
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hyb_phase_q <= 1'b0;
        end else begin
            hyb_phase_q <= hyb_phase_d;
        end
    end

    mtd_debounce #(
        .COUNT_W(COUNT_W)
    ) u_debounce (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .step(step), // see [R18]
        .condition(condition),
        .clear_mode(ths_x_hi_q[mtd_pkg::THS_HI_DBMODE]), // see [R8]
        .target(count_tgt_q),
        .hit(hit),
        .count()
    );

    // Register writes; reserved top bits of Y and Z high stay zero
    always_comb begin
        cfg_d = cfg_q;
        ths_x_hi_d = ths_x_hi_q;
        ths_x_lo_d = ths_x_lo_q;
        ths_y_hi_d = ths_y_hi_q;
        ths_y_lo_d = ths_y_lo_q;
        ths_z_hi_d = ths_z_hi_q;
        ths_z_lo_d = ths_z_lo_q;
        count_tgt_d = count_tgt_q;
        if (reg_wr_en) begin
            case (reg_addr)
                mtd_pkg::OFF_CFG: begin
                    cfg_d = reg_wr_data;
                end
                mtd_pkg::OFF_THS_X_HI: begin
                    ths_x_hi_d = reg_wr_data; // see [R7]
                end
                mtd_pkg::OFF_THS_X_LO: begin
                    ths_x_lo_d = reg_wr_data;
                end
                mtd_pkg::OFF_THS_Y_HI: begin
                    ths_y_hi_d = reg_wr_data & mtd_pkg::THS_HI_MASK; // see [R7]
                end
                mtd_pkg::OFF_THS_Y_LO: begin
                    ths_y_lo_d = reg_wr_data;
                end
                mtd_pkg::OFF_THS_Z_HI: begin
                    ths_z_hi_d = reg_wr_data & mtd_pkg::THS_HI_MASK; // see [R7]
                end
                mtd_pkg::OFF_THS_Z_LO: begin
                    ths_z_lo_d = reg_wr_data;
                end
                mtd_pkg::OFF_COUNT: begin
                    count_tgt_d = COUNT_W'(reg_wr_data); // see [R10]
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= mtd_pkg::REG_RESET;
            ths_x_hi_q <= mtd_pkg::REG_RESET;
            ths_x_lo_q <= mtd_pkg::REG_RESET;
            ths_y_hi_q <= mtd_pkg::REG_RESET;
            ths_y_lo_q <= mtd_pkg::REG_RESET;
            ths_z_hi_q <= mtd_pkg::REG_RESET;
            ths_z_lo_q <= mtd_pkg::REG_RESET;
            count_tgt_q <= COUNT_W'(mtd_pkg::REG_RESET);
        end else begin
            cfg_q <= cfg_d;
            ths_x_hi_q <= ths_x_hi_d;
            ths_x_lo_q <= ths_x_lo_d;
            ths_y_hi_q <= ths_y_hi_d;
            ths_y_lo_q <= ths_y_lo_d;
            ths_z_hi_q <= ths_z_hi_d;
            ths_z_lo_q <= ths_z_lo_d;
            count_tgt_q <= count_tgt_d;
        end
    end

    assign src_read = reg_rd_en && (reg_addr == mtd_pkg::OFF_SRC);

    // Event source state; a hit in the read cycle survives the clear
    always_comb begin
        active_d = active_q;
        high_d = high_q;
        pol_d = pol_q;
        if (src_read && cfg_q[mtd_pkg::CFG_LATCH_EN]) begin
            active_d = 1'b0; // see [R14]
            high_d = '0;
            pol_d = '0;
        end
        if (step) begin
            if (cfg_q[mtd_pkg::CFG_LATCH_EN]) begin
                if (hit) begin
                    active_d = 1'b1; // see [R14]
                    high_d = axis_hit; // see [R2]
                    pol_d = negative & axis_hit; // see [R4]
                end
            end else begin
                active_d = hit; // see [R1]
                high_d = hit ? axis_hit : 3'h0; // see [R2]
                pol_d = hit ? (negative & axis_hit) : 3'h0; // see [R4]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            active_q <= 1'b0;
            high_q <= 3'h0;
            pol_q <= 3'h0;
        end else begin
            active_q <= active_d; // see [R18]
            high_q <= high_d;
            pol_q <= pol_d;
        end
    end

    // Disabling an axis hides its flags at once, even while latched
    always_comb begin
        src_view = mtd_pkg::REG_RESET;
        src_view[mtd_pkg::SRC_ACTIVE] = active_q; // see [R1]
        src_view[mtd_pkg::SRC_Z_HIGH] = high_q[2] & axis_en[2]; // see [R3]
        src_view[mtd_pkg::SRC_Z_POL] = pol_q[2] & axis_en[2]; // see [R3]
        src_view[mtd_pkg::SRC_Y_HIGH] = high_q[1] & axis_en[1]; // see [R3]
        src_view[mtd_pkg::SRC_Y_POL] = pol_q[1] & axis_en[1]; // see [R3]
        src_view[mtd_pkg::SRC_X_HIGH] = high_q[0] & axis_en[0]; // see [R3]
        src_view[mtd_pkg::SRC_X_POL] = pol_q[0] & axis_en[0]; // see [R3]
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_data_d = rd_data_q;
        if (reg_rd_en) begin
            case (reg_addr)
                mtd_pkg::OFF_CFG: begin
                    rd_data_d = cfg_q;
                end
                mtd_pkg::OFF_SRC: begin
                    rd_data_d = src_view;
                end
                mtd_pkg::OFF_THS_X_HI: begin
                    rd_data_d = ths_x_hi_q;
                end
                mtd_pkg::OFF_THS_X_LO: begin
                    rd_data_d = ths_x_lo_q;
                end
                mtd_pkg::OFF_THS_Y_HI: begin
                    rd_data_d = ths_y_hi_q;
                end
                mtd_pkg::OFF_THS_Y_LO: begin
                    rd_data_d = ths_y_lo_q;
                end
                mtd_pkg::OFF_THS_Z_HI: begin
                    rd_data_d = ths_z_hi_q;
                end
                mtd_pkg::OFF_THS_Z_LO: begin
                    rd_data_d = ths_z_lo_q;
                end
                mtd_pkg::OFF_COUNT: begin
                    rd_data_d = 8'(count_tgt_q);
                end
                default: begin
                    rd_data_d = mtd_pkg::REG_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= mtd_pkg::REG_RESET;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign reg_rd_data = rd_data_q;
    assign event_active_flag = active_q;
    assign wake_event = active_q & cfg_q[mtd_pkg::CFG_WAKE_EN];

    // Shared lines: this flag only adds to whatever else drives them
    always_comb begin
        irq_line_one = irq_one_other;
        irq_line_two = irq_two_other;
        if (cfg_q[mtd_pkg::CFG_INT_EN] && active_q) begin
            if (cfg_q[mtd_pkg::CFG_INT_ROUTE]) begin
                irq_line_one = 1'b1; // see [R17]
            end else begin
                irq_line_two = 1'b1; // see [R17]
            end
        end
    end
endmodule : mtd_top
`default_nettype wire

// *** shared/mtd_pkg.sv ***
// Constants for the magnetic threshold event detector: register offsets,
// field positions, reset values and widths.
// Assumes byte-wide registers reached over the device's serial register port.
// Notes on behaviour
// [R1] Event flag set when configured combination true
// [R2] Source shows current or latched triggering event
// [R3] Axis flags read zero when axis disabled
// [R4] Polarity zero positive, one negative
// [R5] Unsigned 15-bit thresholds, 0.1 uT steps
// [R6] Compare raw samples before offset correction
// [R7] Threshold split high/low; X bit7 debounce mode
// [R8] Mode one: clear counter when condition false
// [R9] Mode zero: decrement counter when condition false
// [R10] Flag set when counter reaches programmed count
// [R11] Counter saturates at programmed count
// [R12] Counter advances once per data rate period
// [R13] Hybrid mode doubles the debounce time step
// [R14] Latched flag cleared only by source read
// [R15] Logic zero: all enabled axes at/below
// [R16] Logic one: any enabled axis at/above
// [R17] Routing bit picks interrupt line one/two
// [R18] Evaluate once per new sample, hold between
package mtd_pkg;
    // Register offsets
    localparam logic [7:0] OFF_CFG = 8'h52;
    localparam logic [7:0] OFF_SRC = 8'h53;
    localparam logic [7:0] OFF_THS_X_HI = 8'h54;
    localparam logic [7:0] OFF_THS_X_LO = 8'h55;
    localparam logic [7:0] OFF_THS_Y_HI = 8'h56;
    localparam logic [7:0] OFF_THS_Y_LO = 8'h57;
    localparam logic [7:0] OFF_THS_Z_HI = 8'h58;
    localparam logic [7:0] OFF_THS_Z_LO = 8'h59;
    localparam logic [7:0] OFF_COUNT = 8'h5A;
    // Configuration fields
    localparam int CFG_LATCH_EN = 7;
    localparam int CFG_LOGIC_OR = 6;
    localparam int CFG_EN_Z = 5;
    localparam int CFG_EN_Y = 4;
    localparam int CFG_EN_X = 3;
    localparam int CFG_WAKE_EN = 2;
    localparam int CFG_INT_EN = 1;
    localparam int CFG_INT_ROUTE = 0;
    // Source fields
    localparam int SRC_ACTIVE = 7;
    localparam int SRC_Z_HIGH = 5;
    localparam int SRC_Z_POL = 4;
    localparam int SRC_Y_HIGH = 3;
    localparam int SRC_Y_POL = 2;
    localparam int SRC_X_HIGH = 1;
    localparam int SRC_X_POL = 0;
    // Debounce mode bit in the X high threshold register
    localparam int THS_HI_DBMODE = 7;
    localparam logic [7:0] THS_HI_MASK = 8'h7F;
    // Widths and reset value
    localparam int THS_W = 15;
    localparam int SAMPLE_W = 16;
    localparam int COUNT_W = 8;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Threshold scale in nanotesla per step, for software reference
    localparam int THS_STEP_NT = 100;
    // Data rate ticks per debounce step in hybrid mode
    localparam int HYBRID_TICK_DIV = 2;
endpackage : mtd_pkg

// *** tb/mtd_host_model.sv ***
// Host processor model driving the register port with one-cycle strobes.
// Assumes read data is registered and stands until the next read.
`timescale 1ns/10ps
`default_nettype none
module mtd_host_model (
    // Clock
    input wire logic clk_sys,
    // Register port
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rd_data
);
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        // Idle lines carry junk so a stale address is never mistaken for a request
        reg_addr <= ~a;
        reg_wr_data <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk_sys);
        d = reg_rd_data;
    endtask : rd
endmodule : mtd_host_model
`default_nettype wire

// *** tb/mtd_top_asserts.sv ***
// Port checker for the magnetic threshold event detector.
// Assumes it is bound to mtd_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module mtd_top_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    // Sample timing and shared lines
    input wire logic odr_tick,
    input wire logic irq_one_other,
    input wire logic irq_two_other,
    // Event outputs
    input wire logic event_active_flag,
    input wire logic wake_event,
    input wire logic irq_line_one,
    input wire logic irq_line_two
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic src_rd;
    logic unmapped;
    assign src_rd = reg_rd_en && reg_addr == mtd_pkg::OFF_SRC;
    assign unmapped = reg_addr < mtd_pkg::OFF_CFG || reg_addr > mtd_pkg::OFF_COUNT;
    AST_SRC_ACTIVE:
        assert property (src_rd |=> reg_rd_data[mtd_pkg::SRC_ACTIVE] == $past(event_active_flag))
        else $error("source active bit differs from event flag");
    AST_SRC_RSV:
        assert property (src_rd |=> !reg_rd_data[6]) else $error("reserved source bit set");
    AST_HI_RSV:
        assert property (reg_rd_en && (reg_addr == mtd_pkg::OFF_THS_Y_HI || reg_addr == mtd_pkg::OFF_THS_Z_HI)
            |=> !reg_rd_data[7]) else $error("reserved high threshold bit set");
    AST_UNMAPPED:
        assert property (reg_rd_en && unmapped |=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
    AST_RD_HOLD:
        assert property (!$past(reg_rd_en) |-> $stable(reg_rd_data)) else $error("read data moved without read");
    AST_FLAG_RISE:
        assert property ($rose(event_active_flag) |-> $past(odr_tick)) else $error("flag rose without tick");
    AST_FLAG_HOLD:
        assert property ($changed(event_active_flag) |-> $past(odr_tick) || $past(src_rd) || $past(reg_wr_en))
        else $error("flag changed between samples");
    AST_WAKE:
        assert property (wake_event |-> event_active_flag) else $error("wake without event");
    AST_IRQ_PASS:
        assert property (!event_active_flag |-> irq_line_one == irq_one_other && irq_line_two == irq_two_other)
        else $error("irq line not equal to other source");
    AST_IRQ_OR:
        assert property ((irq_one_other |-> irq_line_one) and (irq_two_other |-> irq_line_two))
        else $error("other source lost on irq line");
    AST_IRQ_ONE_LINE:
        assert property (!(irq_line_one && !irq_one_other && irq_line_two && !irq_two_other))
        else $error("event routed to both lines");
endmodule : mtd_top_asserts
bind mtd_top mtd_top_asserts u_asserts (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .odr_tick(odr_tick),
    .irq_one_other(irq_one_other), .irq_two_other(irq_two_other), .event_active_flag(event_active_flag),
    .wake_event(wake_event), .irq_line_one(irq_line_one), .irq_line_two(irq_line_two));
`default_nettype wire

// *** tb/mtd_top_tb.sv ***
// Self-checking bench for the magnetic threshold event detector.
// Assumes a 250 MHz clock and a host model owning the register port.
`timescale 1ns/10ps
`default_nettype none
module mtd_top_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr;
    logic [7:0] reg_wr_data;
    logic [7:0] reg_rd_data;
    logic reg_wr_en;
    logic reg_rd_en;
    logic odr_tick = 1'b0;
    logic hybrid_mode = 1'b0;
    logic irq_one_other = 1'b0;
    logic irq_two_other = 1'b0;
    logic [mtd_pkg::SAMPLE_W-1:0] mx = 16'h0000;
    logic [mtd_pkg::SAMPLE_W-1:0] my = 16'h0000;
    logic [mtd_pkg::SAMPLE_W-1:0] mz = 16'h0000;
    logic flag;
    logic wake;
    logic irq1;
    logic irq2;
    int mismatches = 0;
    int n_compared = 0;
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    mtd_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));
    mtd_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .odr_tick(odr_tick),
        .hybrid_mode(hybrid_mode), .mag_x_raw(mx), .mag_y_raw(my), .mag_z_raw(mz),
        .irq_one_other(irq_one_other), .irq_two_other(irq_two_other), .event_active_flag(flag),
        .wake_event(wake), .irq_line_one(irq1), .irq_line_two(irq2));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk($sformatf("register %h", a), exp, d);
    endtask : rc
    // One data-rate tick; samples are junk outside the tick cycle
    task automatic tick(input logic [15:0] x, input logic [15:0] y, input logic exp);
        @(posedge clk_sys);
        odr_tick <= 1'b1;
        mx <= x;
        my <= y;
        mz <= 16'h7FFF;
        @(posedge clk_sys);
        odr_tick <= 1'b0;
        mx <= ~x;
        my <= ~y;
        mz <= 16'h8000;
        @(posedge clk_sys);
        chk("event flag", {7'h00, exp}, {7'h00, flag});
    endtask : tick
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int a = 32'h52; a <= 32'h5A; a++) begin
            rc(a[7:0], 8'h00);
        end
        host.wr(mtd_pkg::OFF_THS_X_HI, 8'hFF);
        rc(mtd_pkg::OFF_THS_X_HI, 8'hFF);
        host.wr(mtd_pkg::OFF_THS_Z_HI, 8'hFF);
        rc(mtd_pkg::OFF_THS_Z_HI, 8'h7F);
        host.wr(mtd_pkg::OFF_SRC, 8'hFF);
        rc(mtd_pkg::OFF_SRC, 8'h00);
        rc(8'h60, 8'h00);
        // Threshold 0x0100 on X and Y, decrement mode, target two
        host.wr(mtd_pkg::OFF_THS_X_HI, 8'h01);
        host.wr(mtd_pkg::OFF_THS_Y_HI, 8'h01);
        host.wr(mtd_pkg::OFF_COUNT, 8'h02);
        host.wr(mtd_pkg::OFF_CFG, 8'h4F);
        tick(16'h0100, 16'h7FFF, 1'b0);
        tick(16'h0100, 16'h7FFF, 1'b1);
        chk("irq lines", 8'h02, {6'h00, irq1, irq2});
        chk("wake", 8'h01, {7'h00, wake});
        rc(mtd_pkg::OFF_SRC, 8'h82);
        tick(16'hFE00, 16'h0000, 1'b1);
        rc(mtd_pkg::OFF_SRC, 8'h83);
        tick(16'h00FF, 16'h0000, 1'b0);
        tick(16'h0100, 16'h0000, 1'b1);
        host.wr(mtd_pkg::OFF_THS_X_HI, 8'h81);
        tick(16'h00FF, 16'h0000, 1'b0);
        tick(16'h0100, 16'h0000, 1'b0);
        tick(16'h0100, 16'h0000, 1'b1);
        host.wr(mtd_pkg::OFF_CFG, 8'h4E);
        irq_one_other <= 1'b1;
        @(posedge clk_sys);
        chk("irq lines", 8'h03, {6'h00, irq1, irq2});
        irq_one_other <= 1'b0;
        // All enabled axes at or below threshold, no debounce
        host.wr(mtd_pkg::OFF_COUNT, 8'h00);
        host.wr(mtd_pkg::OFF_CFG, 8'h18);
        tick(16'h0100, 16'hFF00, 1'b1);
        chk("wake", 8'h00, {7'h00, wake});
        rc(mtd_pkg::OFF_SRC, 8'h8E);
        tick(16'h0101, 16'h0000, 1'b0);
        rc(mtd_pkg::OFF_SRC, 8'h00);
        // Latched event cleared only by a source read
        host.wr(mtd_pkg::OFF_CFG, 8'hC8);
        tick(16'h0200, 16'h0000, 1'b1);
        tick(16'h0000, 16'h0000, 1'b1);
        rc(mtd_pkg::OFF_SRC, 8'h82);
        chk("event flag", 8'h00, {7'h00, flag});
        rc(mtd_pkg::OFF_SRC, 8'h00);
        // Hybrid mode steps on every second tick only
        host.wr(mtd_pkg::OFF_COUNT, 8'h01);
        host.wr(mtd_pkg::OFF_CFG, 8'h48);
        hybrid_mode <= 1'b1;
        tick(16'h0200, 16'h0000, 1'b0);
        tick(16'h0200, 16'h0000, 1'b1);
        repeat (5) @(posedge clk_sys);
        chk("event flag", 8'h01, {7'h00, flag});
        // Interrupt disabled: lines show only the other sources
        irq_two_other <= 1'b1;
        @(posedge clk_sys);
        chk("irq lines", 8'h01, {6'h00, irq1, irq2});
        irq_two_other <= 1'b0;
        end_of_test();
    end
endmodule : mtd_top_tb
`default_nettype wire
